// ==== design/vmsh_cause_if.sv ====
// Carries stop causes to the arbiter and the resolved stop style back.
`timescale 1ns/1ps
interface vmsh_cause_if;
  import vmsh_pkg::*;
  vmsh_cause_s cause;
  vmsh_style_e style;
  logic        lock;
  logic        to_real;
  logic        enc_stop;
  logic        sync_loss;
  modport arb (input cause, output style, lock, to_real, enc_stop, sync_loss);
  modport top (output cause, input style, lock, to_real, enc_stop, sync_loss);
endinterface

// ==== design/vmsh_map.svh ====
// Register map, field positions, reset values and fixed codes of the stop handler.
`ifndef VMSH_MAP_SVH
`define VMSH_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VMSH_OFF_CTRL      12'h000
`define VMSH_OFF_STATUS    12'h004
`define VMSH_OFF_EVENT     12'h008
`define VMSH_OFF_MASK      12'h00C
`define VMSH_OFF_SMOOTH    12'h010
`define VMSH_OFF_SERVO_ERR 12'h014
`define VMSH_OFF_SERVO_CODE 12'h018
`define VMSH_OFF_MINOR     12'h01C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define VMSH_CTRL_STOP      0
`define VMSH_CTRL_RAPID     1
`define VMSH_CTRL_SERVO_OFF 2
`define VMSH_CTRL_READY     3
`define VMSH_CTRL_CPU_RUN   4
`define VMSH_CTRL_CLUTCH    5
`define VMSH_CTRL_WIDTH     6
`define VMSH_CTRL_RESET     6'h00
`define VMSH_CMD_START      8
`define VMSH_CMD_R2V        9
`define VMSH_CMD_V2R        10
`define VMSH_CMD_ERR_RESET  11

// ----------------------------------------------------------------------------
// Event register fields (write one to clear)
// ----------------------------------------------------------------------------
`define VMSH_EV_MINOR      0
`define VMSH_EV_FORCED     1
`define VMSH_EV_SERVO      2
`define VMSH_EV_WATCHDOG   3
`define VMSH_EV_OTHER      4
`define VMSH_EV_ENC        5
`define VMSH_EV_SYNC       6
`define VMSH_EV_WIDTH      7
`define VMSH_EV_RESET      7'h00

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define VMSH_MINOR_CODE    16'd200
`define VMSH_SMOOTH_RESET  16'h0064

`endif

// ==== design/vmsh_pkg.sv ====
// Types shared by the stop handler and its stop-style arbiter.
package vmsh_pkg;

  // --------------------------------------------------------------------------
  // Operating modes and stop styles
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VMSH_REAL = 2'b00,
    VMSH_RUN  = 2'b01,
    VMSH_STOP = 2'b11,
    VMSH_LOCK = 2'b10
  } vmsh_mode_e;

  typedef enum logic [1:0] {
    VMSH_NONE  = 2'b00,
    VMSH_DECEL = 2'b01,
    VMSH_RAPID = 2'b10,
    VMSH_IMMED = 2'b11
  } vmsh_style_e;

  // Stop causes present in the current operation cycle.
  typedef struct packed {
    logic stop;
    logic rapid;
    logic servo_off;
    logic ready_lost;
    logic cpu_stop;
    logic forced;
    logic servo;
    logic watchdog;
    logic other;
    logic enc;
  } vmsh_cause_s;

  // The encoding orders styles by severity, so the larger code wins.
  function automatic vmsh_style_e vmsh_style_max(input vmsh_style_e a, input vmsh_style_e b);
    vmsh_style_max = (a > b) ? a : b;
  endfunction

endpackage

// ==== design/vmsh_stop_arbiter.sv ====
// Resolves concurrent stop causes into one stop style and its consequences.
`timescale 1ns/1ps
module vmsh_stop_arbiter (
  vmsh_cause_if.arb cif
);
  import vmsh_pkg::*;

  // --------------------------------------------------------------------------
  // Per-style groups of causes
  // --------------------------------------------------------------------------
  wire         want_immed;
  wire         want_rapid;
  wire         want_decel;
  vmsh_style_e lo_style;

  assign want_immed = cif.cause.forced | cif.cause.watchdog;
  assign want_rapid = cif.cause.rapid | cif.cause.servo;
  assign want_decel = cif.cause.stop | cif.cause.servo_off | cif.cause.ready_lost |
                      cif.cause.cpu_stop | cif.cause.other | cif.cause.enc;

  assign lo_style  = vmsh_style_max(want_decel ? VMSH_DECEL : VMSH_NONE,
                                    want_rapid ? VMSH_RAPID : VMSH_NONE);
  assign cif.style = want_immed ? VMSH_IMMED : lo_style;

  // --------------------------------------------------------------------------
  // Consequences beyond the style
  // --------------------------------------------------------------------------
  // encoder error blocks continuation
  assign cif.lock      = want_immed | cif.cause.servo | cif.cause.enc;
  assign cif.to_real   = cif.cause.ready_lost | cif.cause.cpu_stop;
  assign cif.enc_stop  = cif.cause.servo_off | cif.to_real | cif.lock;
  assign cif.sync_loss = want_immed | cif.cause.servo;

endmodule // vmsh_stop_arbiter

// ==== design/vmsh_stop_handler.sv ====
// Virtual-mode stop handler with APB registers, cause arbitration and interrupt.
//
// Function
// - Stop command decelerates, rapid stop command stops rapidly; clear and restart.
// - Servo-off decelerates; clutch open, servo on, close.
// - Ready drop: minor 200, decelerate, re-request.
// - CPU stop: minor 200, decelerate, re-request.
// - Forced stop: immediate, servo off, locked.
// - Servo error: flag, code, failing axis off.
// - Watchdog/reset/power loss: immediate stop, servo off.
// - Other errors decelerate, continue after removal.
// - Encoder error locks until real round trip.
// - Encoder inputs resume after mode round trip.
// - Sync-mismatch warning on desynchronising stops.
`timescale 1ns/1ps
`include "vmsh_map.svh"
module vmsh_stop_handler #(
  parameter int NUM_AXES    = 4,
  parameter bit ENC_MONITOR = 1'b0
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                forced_stop_pin,
  input  wire logic                watchdog_pin,
  input  wire logic                system_reset_pin,
  input  wire logic                power_loss_pin,
  input  wire logic                other_error_pin,
  input  wire logic                enc_error_pin,
  input  wire logic [NUM_AXES-1:0] servo_error_pin,
  input  wire logic [15:0]         servo_code_pin,
  output logic                     decel_stop,
  output logic                     rapid_stop,
  output logic      [NUM_AXES-1:0] immediate_stop,
  output logic      [NUM_AXES-1:0] servo_off,
  output logic                     enc_input_enable,
  output logic                     virtual_mode,
  output logic                     irq
);
  import vmsh_pkg::*;
  localparam int SW = 6 + NUM_AXES + 16;
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [SW-1:0]       sync_a;
  logic [SW-1:0]       sync_b;
  logic [SW-1:0]       sync_q;
  wire  [SW-1:0]       pins;
  wire  [NUM_AXES-1:0] s_servo;
  wire  [15:0]         s_code;
  wire                 s_forced;
  wire                 s_wdt;
  wire                 s_other;
  wire                 s_enc;
  wire  [5:0]          rise;
  assign pins = {servo_code_pin, servo_error_pin, forced_stop_pin, watchdog_pin, system_reset_pin,
                 power_loss_pin, other_error_pin, enc_error_pin};
  // Two synchroniser flops and an edge flop per pin; the code bus is only read once the error level has settled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_q <= '0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      sync_q <= sync_b;
    end
  end

  // Named views of the synchronised pins and their rising edges.
  assign s_code   = sync_b[SW-1 -: 16];
  assign s_servo  = sync_b[6 +: NUM_AXES];
  assign s_forced = sync_b[5];
  assign s_wdt    = sync_b[4] | sync_b[3] | sync_b[2];
  assign s_other  = sync_b[1];
  assign s_enc    = sync_b[0];
  assign rise     = sync_b[5:0] & ~sync_q[5:0];
  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic [`VMSH_CTRL_WIDTH-1:0] ctrl;
  logic [`VMSH_EV_WIDTH-1:0]   event_q;
  logic [`VMSH_EV_WIDTH-1:0]   mask;
  logic [15:0]                 smooth;
  logic [NUM_AXES-1:0]         servo_err;
  logic [15:0]                 servo_code;
  logic [15:0]                 minor_code;
  logic [15:0]                 timer;
  vmsh_mode_e                  mode;
  vmsh_style_e                 style_q;
  wire                         wr;
  wire                         rd_setup;
  wire                         hit;
  wire                         wr_ctrl;
  wire                         start_p;
  wire                         r2v_p;
  wire                         v2r_p;
  wire                         err_reset_p;
  logic [31:0]                 rd_mux;
  // Zero wait states: the access phase always completes on its first edge.
  assign pready   = 1'b1;
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit      = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
  assign pslverr  = psel & penable & ~hit;
  assign wr_ctrl  = wr && (paddr == `VMSH_OFF_CTRL);
  // Command bits above the stored ones are single-cycle pulses, never stored.
  assign start_p     = wr_ctrl & pwdata[`VMSH_CMD_START];
  assign r2v_p       = wr_ctrl & pwdata[`VMSH_CMD_R2V];
  assign v2r_p       = wr_ctrl & pwdata[`VMSH_CMD_V2R];
  assign err_reset_p = wr_ctrl & pwdata[`VMSH_CMD_ERR_RESET];
  // Read selection; unmapped words read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `VMSH_OFF_CTRL:       rd_mux[`VMSH_CTRL_WIDTH-1:0] = ctrl;
      `VMSH_OFF_STATUS:     rd_mux[7:0] = {2'b00, enc_input_enable, irq, style_q, mode};
      `VMSH_OFF_EVENT:      rd_mux[`VMSH_EV_WIDTH-1:0] = event_q;
      `VMSH_OFF_MASK:       rd_mux[`VMSH_EV_WIDTH-1:0] = mask;
      `VMSH_OFF_SMOOTH:     rd_mux[15:0] = smooth;
      `VMSH_OFF_SERVO_ERR:  rd_mux[NUM_AXES-1:0] = servo_err;
      `VMSH_OFF_SERVO_CODE: rd_mux[15:0] = servo_code;
      `VMSH_OFF_MINOR:      rd_mux[15:0] = minor_code;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so it leaves a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Writable configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= `VMSH_CTRL_RESET;
      mask   <= `VMSH_EV_RESET;
      smooth <= `VMSH_SMOOTH_RESET;
    end else if (wr) begin
      if (paddr == `VMSH_OFF_CTRL)   ctrl   <= pwdata[`VMSH_CTRL_WIDTH-1:0];
      if (paddr == `VMSH_OFF_MASK)   mask   <= pwdata[`VMSH_EV_WIDTH-1:0];
      if (paddr == `VMSH_OFF_SMOOTH) smooth <= pwdata[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // Cause collection and arbitration
  // --------------------------------------------------------------------------
  vmsh_cause_if cif ();
  wire active;
  wire clutch_rise;
  logic clutch_q;
  // Causes only count while the virtual axes are in operation.
  assign active = (mode != VMSH_REAL);
  assign cif.cause.stop       = active & ctrl[`VMSH_CTRL_STOP];
  assign cif.cause.rapid      = active & ctrl[`VMSH_CTRL_RAPID];
  assign cif.cause.servo_off  = active & ctrl[`VMSH_CTRL_SERVO_OFF];
  assign cif.cause.ready_lost = active & ~ctrl[`VMSH_CTRL_READY];
  assign cif.cause.cpu_stop   = active & ~ctrl[`VMSH_CTRL_CPU_RUN];
  assign cif.cause.forced     = active & s_forced;
  assign cif.cause.servo      = active & (|s_servo);
  assign cif.cause.watchdog   = active & s_wdt;
  assign cif.cause.other      = active & s_other;
  assign cif.cause.enc        = active & s_enc;
  assign clutch_rise          = ctrl[`VMSH_CTRL_CLUTCH] & ~clutch_q;

  vmsh_stop_arbiter u_arb (
    .cif (cif.arb)
  );
  // --------------------------------------------------------------------------
  // Mode state machine
  // --------------------------------------------------------------------------
  vmsh_mode_e  next_mode;
  vmsh_style_e next_style;
  logic [15:0] next_timer;
  wire         can_enter;
  wire         resume;
  assign can_enter = ctrl[`VMSH_CTRL_READY] & ctrl[`VMSH_CTRL_CPU_RUN] & ~s_forced & ~s_wdt &
                     ~event_q[`VMSH_EV_SYNC];
  assign resume = start_p | (clutch_rise & ~ctrl[`VMSH_CTRL_SERVO_OFF]);
  always_comb begin
    next_mode  = mode;
    next_style = style_q;
    next_timer = (timer != 16'h0000) ? timer - 16'h0001 : timer;
    unique case (mode)
      VMSH_REAL: begin
        next_style = VMSH_NONE;
        if (r2v_p && can_enter) next_mode = VMSH_RUN;
      end
      VMSH_RUN: begin
        if (cif.style != VMSH_NONE) begin
          next_style = cif.style;
          next_timer = smooth;
          next_mode  = cif.lock ? VMSH_LOCK : VMSH_STOP;
        end
      end
      VMSH_STOP: begin
        next_style = vmsh_style_max(style_q, cif.style);
        if (cif.lock) begin
          next_mode = VMSH_LOCK;
        end else if (timer == 16'h0000 && cif.to_real) begin
          next_mode = VMSH_REAL;
        end else if (timer == 16'h0000 && cif.style == VMSH_NONE && resume) begin
          next_style = VMSH_NONE;
          next_mode  = VMSH_RUN;
        end
      end
      VMSH_LOCK: begin
        next_style = vmsh_style_max(style_q, cif.style);
        if (v2r_p && !s_forced && !s_wdt) next_mode = VMSH_REAL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode     <= VMSH_REAL;
      style_q  <= VMSH_NONE;
      timer    <= 16'h0000;
      clutch_q <= 1'b0;
    end else begin
      mode     <= next_mode;
      style_q  <= next_style;
      timer    <= next_timer;
      clutch_q <= ctrl[`VMSH_CTRL_CLUTCH];
    end
  end

  // --------------------------------------------------------------------------
  // Error flags, codes and sticky events
  // --------------------------------------------------------------------------
  logic [`VMSH_EV_WIDTH-1:0] ev_set;
  wire  [`VMSH_EV_WIDTH-1:0] ev_clr;
  wire  [NUM_AXES-1:0]       servo_set;
  wire                       minor_set;
  assign minor_set = cif.to_real & (mode == VMSH_RUN);
  assign servo_set = s_servo & {NUM_AXES{active}};
  assign ev_clr    = (wr && paddr == `VMSH_OFF_EVENT) ? pwdata[`VMSH_EV_WIDTH-1:0] : `VMSH_EV_RESET;
  always_comb begin
    ev_set                   = `VMSH_EV_RESET;
    ev_set[`VMSH_EV_MINOR]   = minor_set;
    ev_set[`VMSH_EV_FORCED]  = rise[5] & active;
    ev_set[`VMSH_EV_SERVO]   = |(servo_set & ~servo_err);
    ev_set[`VMSH_EV_WATCHDOG] = (rise[4] | rise[3] | rise[2]) & active;
    ev_set[`VMSH_EV_OTHER]   = rise[1] & active;
    ev_set[`VMSH_EV_ENC]     = rise[0] & active;
    ev_set[`VMSH_EV_SYNC]    = cif.sync_loss;
  end

  // A set in the same cycle as its clear wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q    <= `VMSH_EV_RESET;
      servo_err  <= '0;
      servo_code <= 16'h0000;
      minor_code <= 16'h0000;
      irq        <= 1'b0;
    end else begin
      event_q <= ev_set | (event_q & ~ev_clr);
      servo_err <= servo_set | (servo_err & ~{NUM_AXES{err_reset_p && mode == VMSH_REAL}});
      if (ev_set[`VMSH_EV_SERVO]) servo_code <= s_code;
      if (minor_set) minor_code <= `VMSH_MINOR_CODE;
      irq <= |((ev_set | (event_q & ~ev_clr)) & mask);
    end
  end

  // --------------------------------------------------------------------------
  // Output module and encoder drive
  // --------------------------------------------------------------------------
  wire                stopping;
  wire                imm_all;
  wire [NUM_AXES-1:0] next_imm;
  wire [NUM_AXES-1:0] next_off;
  logic               enc_en;
  wire                next_enc;
  assign stopping = (next_mode == VMSH_STOP) || (next_mode == VMSH_LOCK);
  assign imm_all  = stopping & (next_style == VMSH_IMMED);
  assign next_imm = {NUM_AXES{imm_all}} | (servo_set & {NUM_AXES{stopping}});
  assign next_off = next_imm | {NUM_AXES{(mode == VMSH_STOP) && timer == 16'h0000 &&
                                         ctrl[`VMSH_CTRL_SERVO_OFF]}};
  assign next_enc = ENC_MONITOR ? 1'b1 :
                    (mode == VMSH_REAL) ? (r2v_p & can_enter) | enc_en :
                    enc_en & ~cif.enc_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decel_stop       <= 1'b0;
      rapid_stop       <= 1'b0;
      immediate_stop   <= '0;
      servo_off        <= '0;
      enc_en           <= 1'b0;
      enc_input_enable <= 1'b0;
      virtual_mode     <= 1'b0;
    end else begin
      decel_stop       <= stopping & (next_style == VMSH_DECEL);
      rapid_stop       <= stopping & (next_style == VMSH_RAPID);
      immediate_stop   <= next_imm;
      servo_off        <= next_off;
      enc_en           <= next_enc;
      enc_input_enable <= next_enc;
      virtual_mode     <= (next_mode != VMSH_REAL);
    end
  end
endmodule // vmsh_stop_handler

// ==== verif/vmsh_servo_model.sv ====
// Behavioural servo amplifier group that reports axis faults.
`timescale 1ns/1ps
module vmsh_servo_model #(
  parameter int NUM_AXES = 4
) (
  input  wire logic                pclk,
  input  wire logic [NUM_AXES-1:0] fault_req,
  input  wire logic [15:0]         code_req,
  output logic      [NUM_AXES-1:0] servo_error_pin,
  output logic      [15:0]         servo_code_pin
);
  logic [NUM_AXES-1:0] armed = '0;
  // Start quiet so nothing unknown reaches the synchronisers.
  initial begin
    servo_error_pin = '0;
    servo_code_pin = 16'h0000;
  end
  // code before flag
  // The code settles a cycle ahead of the flag; when idle it toggles, so a stale code never looks valid.
  always @(posedge pclk) begin
    armed <= fault_req;
    servo_error_pin <= armed & fault_req;
    servo_code_pin <= (|fault_req) ? code_req : ~servo_code_pin;
  end
endmodule // vmsh_servo_model

// ==== verif/vmsh_stop_handler_sva.sv ====
// Port-level checker for the virtual-mode stop handler.
`timescale 1ns/1ps
module vmsh_stop_handler_sva #(
  parameter int NUM_AXES    = 4,
  parameter bit ENC_MONITOR = 1'b0
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [11:0]         paddr,
  input wire logic                pslverr,
  input wire logic                forced_stop_pin,
  input wire logic                watchdog_pin,
  input wire logic                system_reset_pin,
  input wire logic                power_loss_pin,
  input wire logic                other_error_pin,
  input wire logic [NUM_AXES-1:0] servo_error_pin,
  input wire logic                decel_stop,
  input wire logic                rapid_stop,
  input wire logic [NUM_AXES-1:0] immediate_stop,
  input wire logic [NUM_AXES-1:0] servo_off,
  input wire logic                enc_input_enable,
  input wire logic                virtual_mode,
  input wire logic                irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pins pass two synchroniser flops and one output register, so five edges is a safe bound.
  chk_forced_all_immed:
    assert property (virtual_mode && forced_stop_pin |-> ##[0:5] &immediate_stop) else $error("forced stop late");
  chk_wdog_all_immed:
    assert property (virtual_mode && (watchdog_pin || system_reset_pin || power_loss_pin) |-> ##[0:5] &immediate_stop)
      else $error("watchdog group stop late");
  chk_servo_axis_immed:
    assert property (virtual_mode && |servo_error_pin |-> ##[0:5] ((immediate_stop & servo_error_pin) == servo_error_pin))
      else $error("failing axis not stopped");
  chk_other_decel:
    assert property (virtual_mode && other_error_pin |-> ##[0:5] (decel_stop || rapid_stop || |immediate_stop))
      else $error("other error not stopping");
  chk_immed_servo_off:
    assert property ($rose(|immediate_stop) |-> ##[0:1] ((servo_off & immediate_stop) == immediate_stop))
      else $error("immediate stop without servo off");
  chk_one_style:
    assert property (!(decel_stop && rapid_stop)) else $error("two stop styles at once");
  chk_enc_needs_virt:
    assert property (enc_input_enable |-> virtual_mode || ENC_MONITOR) else $error("encoder inputs in real mode");
  chk_enc_rise_entry:
    assert property ($rose(enc_input_enable) |-> $rose(virtual_mode) || ENC_MONITOR)
      else $error("encoder inputs resumed without entry");
  chk_unmapped_err:
    assert property (psel && penable && paddr >= 12'h020 |-> pslverr) else $error("unmapped access accepted");
  cover property (&immediate_stop);
  cover property (rapid_stop && |immediate_stop);
  cover property ($rose(irq));
endmodule // vmsh_stop_handler_sva

bind vmsh_stop_handler vmsh_stop_handler_sva #(.NUM_AXES(NUM_AXES), .ENC_MONITOR(ENC_MONITOR)) vmsh_stop_handler_sva_i (
  .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .forced_stop_pin, .watchdog_pin, .system_reset_pin,
  .power_loss_pin, .other_error_pin, .servo_error_pin, .decel_stop, .rapid_stop, .immediate_stop, .servo_off,
  .enc_input_enable, .virtual_mode, .irq);

// ==== verif/vmsh_stop_handler_tb.sv ====
// Self-checking bench for the virtual-mode stop handler.
`timescale 1ns/1ps
`include "vmsh_map.svh"
module vmsh_stop_handler_tb;
  import vmsh_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oth = 1'b0, enc = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [3:0]  lk = '0, flt = '0, imm, soff, serr;
  logic [15:0] code, creq = '0;
  logic        pready, pslverr, er, dec, rap, ene, vm, irq;
  int          errors = 0, n_tests = 0;
  // A 10 MHz clock.
  always #50 pclk = ~pclk;
  vmsh_stop_handler vmsh_stop_handler_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .forced_stop_pin(lk[0]), .watchdog_pin(lk[1]), .system_reset_pin(lk[2]),
    .power_loss_pin(lk[3]), .other_error_pin(oth), .enc_error_pin(enc), .servo_error_pin(serr),
    .servo_code_pin(code), .decel_stop(dec), .rapid_stop(rap), .immediate_stop(imm), .servo_off(soff),
    .enc_input_enable(ene), .virtual_mode(vm), .irq);
  vmsh_servo_model vmsh_servo_model_i (.pclk, .fault_req(flt), .code_req(creq), .servo_error_pin(serr),
    .servo_code_pin(code));
  task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      close_out();
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, '0);
    ck(q, e, m);
  endtask
  task automatic wc(input logic [31:0] d);
    apb(1'b1, `VMSH_OFF_CTRL, d);
  endtask
  task automatic clr;
    apb(1'b1, `VMSH_OFF_EVENT, 32'h0000_007F);
  endtask
  task automatic md(input logic [1:0] e, input string m);
    apb(1'b0, `VMSH_OFF_STATUS, '0);
    ck(q[1:0], e, m);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Enter virtual mode: ready and CPU running, then the switch request.
  task automatic run;
    wc(32'h0000_0018);
    wc(32'h0000_0218);
    wt(2);
    ck(vm, 1'b1, "entry");
    ck(ene, 1'b1, "enc on");
  endtask
  task automatic t_rst;
    rc(`VMSH_OFF_SMOOTH, `VMSH_SMOOTH_RESET, "smooth rst");
    rc(12'h020, 32'h0000_0000, "unmapped");
    ck(er, 1'b1, "slverr");
    apb(1'b1, `VMSH_OFF_SMOOTH, 32'h0000_0004);
    rc(`VMSH_OFF_SMOOTH, 32'h0000_0004, "smooth");
    run();
    $display("test reset done");
  endtask
  // Stop and rapid stop land together, then both clear with a start.
  task automatic t_stop;
    wc(32'h0000_001B);
    wt(2);
    ck(rap, 1'b1, "rapid");
    ck(dec, 1'b0, "decel");
    wt(8);
    wc(32'h0000_0018);
    wc(32'h0000_0118);
    wt(2);
    md(2'b01, "restart");
    wc(32'h0000_001C);
    wt(2);
    ck(dec, 1'b1, "off decel");
    ck(ene, 1'b0, "enc stop");
    wt(8);
    ck(soff, 4'hF, "servo off");
    wc(32'h0000_0018);
    wc(32'h0000_0038);
    wt(2);
    md(2'b01, "clutch");
    ck(ene, 1'b0, "enc held");
    $display("test stop done");
  endtask
  task automatic t_loss;
    for (int i = 0; i < 2; i++) begin
      wc(i ? 32'h0000_0008 : 32'h0000_0010);
      wt(2);
      ck(dec, 1'b1, "loss decel");
      rc(`VMSH_OFF_MINOR, `VMSH_MINOR_CODE, "minor");
      wt(10);
      ck(vm, 1'b0, "real");
      ck(irq, 1'b0, "masked");
      clr();
      run();
    end
    $display("test loss done");
  endtask
  // Each immediate cause locks, refuses re-entry until the warning clears.
  task automatic t_lock;
    apb(1'b1, `VMSH_OFF_MASK, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      lk <= 4'h1 << i;
      wt(4);
      ck(imm, 4'hF, "immed");
      ck(soff, 4'hF, "off");
      ck(irq, i == 0, "irq");
      md(2'b10, "lock");
      apb(1'b0, `VMSH_OFF_EVENT, '0);
      ck(q[6], 1'b1, "sync");
      ck(q[3:1], i ? 3'b100 : 3'b001, "cause");
      @(posedge pclk);
      lk <= '0;
      wt(4);
      wc(32'h0000_0418);
      wc(32'h0000_0218);
      wt(2);
      ck(vm, 1'b0, "refused");
      clr();
      wt(2);
      ck(irq, 1'b0, "irq clr");
      run();
    end
    $display("test lock done");
  endtask
  task automatic t_axis;
    @(posedge pclk);
    creq <= 16'h1234;
    flt <= 4'h2;
    wt(6);
    ck(imm, 4'h2, "axis");
    ck(soff, 4'h2, "axis off");
    ck(rap, 1'b1, "others");
    rc(`VMSH_OFF_SERVO_ERR, 32'h0000_0002, "flag");
    rc(`VMSH_OFF_SERVO_CODE, 32'h0000_1234, "code");
    @(posedge pclk);
    flt <= '0;
    wt(4);
    wc(32'h0000_0418);
    wc(32'h0000_0818);
    rc(`VMSH_OFF_SERVO_ERR, 32'h0000_0000, "err rst");
    clr();
    run();
    $display("test axis done");
  endtask
  task automatic t_other;
    @(posedge pclk);
    oth <= 1'b1;
    wt(4);
    ck(dec, 1'b1, "other");
    @(posedge pclk);
    oth <= 1'b0;
    clr();
    wt(8);
    wc(32'h0000_0118);
    wt(2);
    md(2'b01, "go on");
    @(posedge pclk);
    enc <= 1'b1;
    wt(4);
    md(2'b10, "enc lock");
    ck(ene, 1'b0, "enc off");
    @(posedge pclk);
    enc <= 1'b0;
    wt(4);
    wc(32'h0000_0418);
    clr();
    run();
    $display("test other done");
  endtask
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    wt(3);
    presetn <= 1'b1;
    t_rst();
    t_stop();
    t_loss();
    t_lock();
    t_axis();
    t_other();
    close_out();
  end
endmodule // vmsh_stop_handler_tb
